//--- src/data_trace_view_filter_regs.sv
// Function
// - one event register and three select registers qualify traced data
// - no data, value or coprocessor tracing: registers absent, area reads 0
// - event register holds 17-bit event, upper bits reserved, gates pass
// - single-select bits 31:16 pick comparators 1..16 for exclusion
// - single-select bits 15:0 pick comparators 1..16 for inclusion
// - region-select bits 31:16 pick decode regions 1..16 for exclusion
// - region-select bits 15:0 pick decode regions 1..16 for inclusion
// - no decode regions: region-select reads zero, ignores writes
// - single-select exists only with data tracing and address comparators
// - exclude-only: pass when no selected exclusion matches
`timescale 1ns/100ps
`include "view_filter_defs.svh"

module data_trace_view_filter_regs
    import view_filter_pkg::*;
#(
    parameter bit DATA_TRACE_PRESENT = 1'b1, // any data tracing option
    parameter bit DATA_ADDR_CMP      = 1'b1, // data address comparators
    parameter int NUM_SINGLE_CMP     = 16,   // single comparators, 0..16
    parameter int NUM_REGIONS        = 16,   // decode regions, 0..16
    parameter int NUM_RANGE_CMP      = 8     // range comparators, 0..8
) (
    input  wire logic                   ref_clk,        // clock
    input  wire logic                   sys_rst,        // sync reset
    input  wire logic                   clk_en,         // run enable, low freezes state
    input  wire logic [11:0]            reg_addr,       // byte address
    input  wire view_filter_pkg::word_t reg_wdata,      // write data
    input  wire logic                   reg_wr,         // write strobe
    input  wire logic                   reg_rd,         // read strobe
    output view_filter_pkg::word_t      reg_rdata,      // read data
    input  wire logic [127:0]           resource_hit,   // event resources
    input  wire logic [15:0]            single_match,   // single cmp hits
    input  wire logic [15:0]            region_match,   // decode hits
    input  wire logic [7:0]             range_match,    // range cmp hits
    input  wire logic                   data_xfer,      // data transfer
    output logic                        data_view_filter, // trace data
    output logic                        view_event      // event state
);

    // a register set is present only when its configuration allows it
    localparam bit EVT_PRESENT    = DATA_TRACE_PRESENT;
    localparam bit SINGLE_PRESENT = DATA_TRACE_PRESENT &&
                                    DATA_ADDR_CMP;
    localparam bit RANGE_PRESENT  = DATA_TRACE_PRESENT &&
                                    DATA_ADDR_CMP;
    localparam bit REGION_PRESENT = DATA_TRACE_PRESENT &&
                                    (NUM_REGIONS > 0);

    view_state_s state_r;
    view_state_s state_nxt;

    logic [9:0]  reg_idx;
    logic        event_now;
    logic        s_incl;
    logic        s_excl;
    logic        g_incl;
    logic        g_excl;
    logic        r_incl;
    logic        r_excl;
    logic        incl_any;
    logic        excl_any;
    logic        pass_now;
    logic [15:0] single_mask;
    logic [15:0] region_mask;
    logic [7:0]  range_mask;

    // ones in the low n bits of a 16-bit field
    function automatic logic [15:0] low_mask16(input int n);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : low_mask16

    // a selection word keeps only implemented resources in both halves
    function automatic word_t sel_word(input word_t w,
                                       input logic [15:0] m);
        return {w[31:16] & m, w[15:0] & m};
    endfunction : sel_word

    always_comb begin
        single_mask = SINGLE_PRESENT ? low_mask16(NUM_SINGLE_CMP)
                                     : 16'h0000;
        region_mask = REGION_PRESENT ? low_mask16(NUM_REGIONS)
                                     : 16'h0000;
        range_mask  = RANGE_PRESENT ? 8'(low_mask16(NUM_RANGE_CMP))
                                    : 8'h00;
    end

    assign reg_idx = reg_addr[11:2];

    view_event_eval u_event (
        .event_def    (state_r.event_def),
        .resource_hit (resource_hit),
        .event_true   (event_now)
    );

    view_match_reduce #(.N(16)) u_single (
        .sel_incl (state_r.single_sel[15:0]),
        .sel_excl (state_r.single_sel[31:`VF_EXCL_LO]),
        .match    (single_match),
        .incl_hit (s_incl),
        .excl_hit (s_excl)
    );

    view_match_reduce #(.N(16)) u_region (
        .sel_incl (state_r.region_sel[15:0]),
        .sel_excl (state_r.region_sel[31:`VF_EXCL_LO]),
        .match    (region_match),
        .incl_hit (g_incl),
        .excl_hit (g_excl)
    );

    view_match_reduce #(.N(8)) u_range (
        .sel_incl (state_r.range_sel[7:0]),
        .sel_excl (state_r.range_sel[15:`VF_RANGE_EXCL_LO]),
        .match    (range_match),
        .incl_hit (r_incl),
        .excl_hit (r_excl)
    );

    always_comb begin
        incl_any = s_incl || g_incl || r_incl;
        excl_any = s_excl || g_excl || r_excl;
        // exclude-only needs no include match
        pass_now = EVT_PRESENT && event_now &&
                   (incl_any || state_r.excl_only) &&
                   !excl_any;
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.rdata = '0;

        // filter stage: registered view of the current transfer
        state_nxt.event_true = EVT_PRESENT && event_now;
        state_nxt.incl_hit   = incl_any;
        state_nxt.excl_hit   = excl_any;
        state_nxt.view       = pass_now && data_xfer;

        if (reg_wr) begin
            case (reg_idx)
                `VF_IDX_EVENT: begin
                    if (EVT_PRESENT) begin
                        // reserved bits 31:17 are not stored
                        state_nxt.event_def =
                            reg_wdata[`VF_EVT_WIDTH-1:0];
                    end
                end
                `VF_IDX_SINGLE: begin
                    if (SINGLE_PRESENT) begin
                        state_nxt.single_sel =
                            sel_word(reg_wdata, single_mask);
                    end
                end
                `VF_IDX_REGION: begin
                    if (REGION_PRESENT) begin
                        state_nxt.region_sel =
                            sel_word(reg_wdata, region_mask);
                    end
                end
                `VF_IDX_RANGE: begin
                    if (RANGE_PRESENT) begin
                        state_nxt.range_sel =
                            {reg_wdata[15:8] & range_mask,
                             reg_wdata[7:0] & range_mask};
                        state_nxt.excl_only =
                            reg_wdata[`VF_EXCL_ONLY_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_idx)
                `VF_IDX_EVENT: begin
                    if (EVT_PRESENT) begin
                        state_nxt.rdata = {15'h0000, state_r.event_def};
                    end
                end
                `VF_IDX_SINGLE: begin
                    if (SINGLE_PRESENT) begin
                        state_nxt.rdata = state_r.single_sel;
                    end
                end
                `VF_IDX_REGION: begin
                    if (REGION_PRESENT) begin
                        state_nxt.rdata = state_r.region_sel;
                    end
                end
                `VF_IDX_RANGE: begin
                    if (RANGE_PRESENT) begin
                        state_nxt.rdata = {15'h0000, state_r.excl_only,
                                           state_r.range_sel};
                    end
                end
                `VF_IDX_STATUS: begin
                    state_nxt.rdata[`VF_STAT_VIEW]  = state_r.view;
                    state_nxt.rdata[`VF_STAT_EVENT] = state_r.event_true;
                    state_nxt.rdata[`VF_STAT_INCL]  = state_r.incl_hit;
                    state_nxt.rdata[`VF_STAT_EXCL]  = state_r.excl_hit;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r.event_def  <= `VF_RST_EVENT;
            state_r.single_sel <= `VF_RST_SEL;
            state_r.region_sel <= `VF_RST_SEL;
            state_r.range_sel  <= 16'h0000;
            state_r.excl_only  <= `VF_RST_EXCL_ONLY;
            state_r.view       <= 1'b0;
            state_r.event_true <= 1'b0;
            state_r.incl_hit   <= 1'b0;
            state_r.excl_hit   <= 1'b0;
            state_r.rdata      <= 32'h00000000;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata        = state_r.rdata;
    assign data_view_filter = state_r.view;
    assign view_event       = state_r.event_true;

endmodule : data_trace_view_filter_regs

//--- src/view_filter_defs.svh
`ifndef VIEW_FILTER_DEFS_SVH
`define VIEW_FILTER_DEFS_SVH

// register indices; byte address is four times the index
`define VF_IDX_EVENT      10'h00C
`define VF_IDX_SINGLE     10'h00D
`define VF_IDX_REGION     10'h00E
`define VF_IDX_RANGE      10'h00F
`define VF_IDX_STATUS     10'h0FE

// enabling-event register fields
`define VF_EVT_WIDTH      17
`define VF_EVT_FCN_HI     16
`define VF_EVT_FCN_LO     14
`define VF_EVT_RESB_HI    13
`define VF_EVT_RESB_LO    7
`define VF_EVT_RESA_HI    6
`define VF_EVT_RESA_LO    0
`define VF_RES_ALWAYS     7'h6F

// selection register fields
`define VF_EXCL_LO        16
`define VF_RANGE_EXCL_LO  8
`define VF_EXCL_ONLY_BIT  16

// status register bits
`define VF_STAT_VIEW      0
`define VF_STAT_EVENT     1
`define VF_STAT_INCL      2
`define VF_STAT_EXCL      3

// reset values
`define VF_RST_EVENT      17'h00000
`define VF_RST_SEL        32'h00000000
`define VF_RST_EXCL_ONLY  1'b0

`endif

//--- src/view_filter_pkg.sv
package view_filter_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [2:0] {
        FCN_A          = 3'b000,
        FCN_NOT_A      = 3'b001,
        FCN_A_AND_B    = 3'b010,
        FCN_NA_AND_B   = 3'b011,
        FCN_NA_AND_NB  = 3'b100,
        FCN_A_OR_B     = 3'b101,
        FCN_NA_OR_B    = 3'b110,
        FCN_NA_OR_NB   = 3'b111
    } view_fcn_e;

    typedef struct packed {
        logic [16:0] event_def;
        logic [31:0] single_sel;
        logic [31:0] region_sel;
        logic [15:0] range_sel;
        logic        excl_only;
        logic        view;
        logic        event_true;
        logic        incl_hit;
        logic        excl_hit;
        word_t       rdata;
    } view_state_s;

endpackage : view_filter_pkg

//--- src/view_event_eval.sv
`timescale 1ns/100ps
`include "view_filter_defs.svh"

module view_event_eval
    import view_filter_pkg::*;
(
    input  wire logic [16:0]  event_def,    // event definition
    input  wire logic [127:0] resource_hit, // event resource states
    output logic              event_true    // event evaluates true
);

    logic [6:0] res_a;
    logic [6:0] res_b;
    logic       a;
    logic       b;
    view_fcn_e  fcn;

    // resource 0x6F is the permanently true resource
    function automatic logic res_val(input logic [6:0] idx,
                                     input logic [127:0] hit);
        res_val = (idx == `VF_RES_ALWAYS) ? 1'b1 : hit[idx];
    endfunction : res_val

    always_comb begin
        res_a = event_def[`VF_EVT_RESA_HI:`VF_EVT_RESA_LO];
        res_b = event_def[`VF_EVT_RESB_HI:`VF_EVT_RESB_LO];
        fcn   = view_fcn_e'(event_def[`VF_EVT_FCN_HI:`VF_EVT_FCN_LO]);
        a     = res_val(res_a, resource_hit);
        b     = res_val(res_b, resource_hit);
        case (fcn)
            FCN_A:         event_true = a;
            FCN_NOT_A:     event_true = !a;
            FCN_A_AND_B:   event_true = a && b;
            FCN_NA_AND_B:  event_true = !a && b;
            FCN_NA_AND_NB: event_true = !a && !b;
            FCN_A_OR_B:    event_true = a || b;
            FCN_NA_OR_B:   event_true = !a || b;
            FCN_NA_OR_NB:  event_true = !a || !b;
            default:       event_true = 1'b0;
        endcase
    end

endmodule : view_event_eval

//--- src/view_match_reduce.sv
`timescale 1ns/100ps

module view_match_reduce #(
    parameter int N = 16                  // resources in this group
) (
    input  wire logic [N-1:0] sel_incl,   // include select bits
    input  wire logic [N-1:0] sel_excl,   // exclude select bits
    input  wire logic [N-1:0] match,      // resource match states
    output logic              incl_hit,   // a selected include matches
    output logic              excl_hit    // a selected exclude matches
);

    function automatic logic sel_hit(input logic [N-1:0] sel,
                                     input logic [N-1:0] m);
        sel_hit = |(sel & m);
    endfunction : sel_hit

    always_comb begin
        incl_hit = sel_hit(sel_incl, match);
        excl_hit = sel_hit(sel_excl, match);
    end

endmodule : view_match_reduce

//--- sim/data_trace_view_filter_regs_checker.sv
`timescale 1ns/100ps
module data_trace_view_filter_regs_checker
    import view_filter_pkg::*;
(
    input wire logic                   ref_clk,          // clock
    input wire logic                   sys_rst,          // sync reset
    input wire logic                   clk_en,           // run enable
    input wire logic [11:0]            reg_addr,         // byte address
    input wire view_filter_pkg::word_t reg_wdata,        // write data
    input wire logic                   reg_wr,           // write strobe
    input wire logic                   reg_rd,           // read strobe
    input wire view_filter_pkg::word_t reg_rdata,        // read data
    input wire logic [15:0]            single_match,     // single hits
    input wire logic [15:0]            region_match,     // region hits
    input wire logic [7:0]             range_match,      // range hits
    input wire logic                   data_xfer,        // transfer
    input wire logic                   data_view_filter, // filter out
    input wire logic                   view_event        // event out
);
    logic [31:0] single_r;
    logic [16:0] range_r;
    logic        no_match;
    // shadow copies of the single and range select registers as software wrote them
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            single_r <= 32'h00000000;
            range_r  <= 17'h00000;
        end else if (clk_en && reg_wr) begin
            if (reg_addr[11:2] == 10'h00D) single_r <= reg_wdata;
            if (reg_addr[11:2] == 10'h00F) range_r <= reg_wdata[16:0];
        end
    end
    assign no_match = region_match == 16'h0 && range_match == 8'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_rdata_idle_zero: assert property (
        clk_en && !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read");
    a_unmapped_reads_zero: assert property (
        clk_en && reg_rd && !(reg_addr[11:2] inside
        {10'h00C, 10'h00D, 10'h00E, 10'h00F, 10'h0FE})
        |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_event_upper_zero: assert property (
        clk_en && reg_rd && reg_addr[11:2] == 10'h00C
        |=> reg_rdata[31:17] == 15'h0)
        else $error("event reserved bits not zero");
    a_range_read_back: assert property (
        clk_en && reg_rd && reg_addr[11:2] == 10'h00F
        |=> reg_rdata == {15'h0, $past(range_r)})
        else $error("range select readback");
    a_view_needs_xfer: assert property (
        clk_en && !data_xfer |=> !data_view_filter)
        else $error("filter passed without transfer");
    a_view_needs_event: assert property (
        data_view_filter |-> view_event)
        else $error("filter passed with event false");
    a_single_excl_blocks: assert property (
        clk_en && |(single_match & single_r[31:16])
        |=> !data_view_filter)
        else $error("single exclude did not block");
    a_range_excl_blocks: assert property (
        clk_en && |(range_match & range_r[15:8])
        |=> !data_view_filter)
        else $error("range exclude did not block");
    a_no_incl_blocks: assert property (
        clk_en && !range_r[16] && no_match && single_match == 16'h0
        |=> !data_view_filter)
        else $error("passed with no include");
    a_single_incl_pass: assert property (
        clk_en && data_xfer && no_match
        && |(single_match & single_r[15:0])
        && !(|(single_match & single_r[31:16]))
        |=> data_view_filter == view_event)
        else $error("single include did not pass");
    a_excl_only_pass: assert property (
        clk_en && data_xfer && range_r[16] && no_match
        && single_match == 16'h0 |=> data_view_filter == view_event)
        else $error("exclude-only did not pass");
    c_view_pass: cover property (data_view_filter);
    c_excl_only: cover property (clk_en && range_r[16] && data_xfer);
    c_read: cover property (clk_en && reg_rd);
endmodule : data_trace_view_filter_regs_checker

bind data_trace_view_filter_regs data_trace_view_filter_regs_checker
    data_trace_view_filter_regs_checker_inst (
    .ref_clk          (ref_clk),
    .sys_rst          (sys_rst),
    .clk_en           (clk_en),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .single_match     (single_match),
    .region_match     (region_match),
    .range_match      (range_match),
    .data_xfer        (data_xfer),
    .data_view_filter (data_view_filter),
    .view_event       (view_event)
);

//--- sim/data_trace_view_filter_regs_tb.sv
`timescale 1ns/100ps
module data_trace_view_filter_regs_tb;
    import view_filter_pkg::*;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         clk_en = 1'b1;
    logic [11:0]  reg_addr = 12'h000;
    word_t        reg_wdata = 32'h0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    word_t        reg_rdata;
    logic [127:0] resource_hit = '0;
    logic [15:0]  single_match = 16'h0;
    logic [15:0]  region_match = 16'h0;
    logic [7:0]   range_match = 8'h0;
    logic         data_xfer = 1'b0;
    logic         data_view_filter;
    logic         view_event;
    integer       seed = 25;
    int           miscompares = 0;
    int           total_checks = 0;
    word_t        d;

    always #20 ref_clk = ~ref_clk;

    data_trace_view_filter_regs data_trace_view_filter_regs_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .resource_hit(resource_hit),
        .single_match(single_match), .region_match(region_match),
        .range_match(range_match), .data_xfer(data_xfer),
        .data_view_filter(data_view_filter), .view_event(view_event));

    // returns {exclude, include, event, pass} for one sampled cycle
    function automatic logic [3:0] model(input logic [16:0] ev,
        input word_t s, r, input logic [16:0] g, input logic [127:0] h,
        input logic [15:0] sm, rm, input logic [7:0] gm);
        logic a, b, e, inc, exc;
        a = ev[6:0] == 7'h6F || h[ev[6:0]];
        b = ev[13:7] == 7'h6F || h[ev[13:7]];
        case (ev[16:14])
            3'd0: e = a;
            3'd1: e = !a;
            3'd2: e = a && b;
            3'd3: e = !a && b;
            3'd4: e = !a && !b;
            3'd5: e = a || b;
            3'd6: e = !a || b;
            default: e = !a || !b;
        endcase
        inc = |(sm & s[15:0]) || |(rm & r[15:0]) || |(gm & g[7:0]);
        exc = |(sm & s[31:16]) || |(rm & r[31:16]) || |(gm & g[15:8]);
        return {exc, inc, e, e && (inc || g[16]) && !exc};
    endfunction : model

    task automatic chk(input string name, input word_t seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input word_t dat);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input word_t exp);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk("reg_rdata", reg_rdata, exp);
    endtask : rd

    task automatic run(input logic [16:0] ev, input word_t s, r,
        input logic [16:0] g, input int n);
        logic [127:0] h;
        logic [15:0]  sm, rm;
        logic [7:0]   gm;
        logic         x, en;
        logic [3:0]   m;
        logic [1:0]   ex;
        wr(12'h030, {15'h0, ev});
        wr(12'h034, s);
        wr(12'h038, r);
        wr(12'h03C, {15'h0, g});
        ex = 2'b00;
        for (int i = 0; i <= n; i++) begin
            @(posedge ref_clk);
            h = {$random(seed), $random(seed), $random(seed), $random(seed)};
            sm = 16'($random(seed) & $random(seed) & $random(seed));
            rm = i[0] ? 16'h0
                      : 16'($random(seed) & $random(seed) & $random(seed));
            gm = i[0] ? 8'h0
                      : 8'($random(seed) & $random(seed) & $random(seed));
            x = 1'($random(seed));
            // first sample always enabled so the first compare is known
            en = (3'($random(seed)) != 3'd0) || (i == 0);
            resource_hit <= h;
            single_match <= sm;
            region_match <= rm;
            range_match <= gm;
            data_xfer <= x;
            clk_en <= en;
            @(negedge ref_clk);
            if (i > 0) begin
                chk("data_view_filter", {31'h0, data_view_filter},
                    {31'h0, ex[1]});
                chk("view_event", {31'h0, view_event}, {31'h0, ex[0]});
            end
            if (en) begin
                m = model(ev, s, r, g, h, sm, rm, gm);
                ex = {m[0] && x, m[1]};
            end
        end
        // one enabled cycle on the last sample, then read the status word
        @(posedge ref_clk);
        clk_en <= 1'b1;
        m = model(ev, s, r, g, h, sm, rm, gm);
        rd(12'h3F8, {28'h0, m[3:1], m[0] && x});
    endtask : run

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 4; k++) rd(12'h030 + 12'(k * 4), 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            wr(12'h030 + 12'(k * 4), d);
            d = d & ((k == 0 || k == 3) ? 32'h0001FFFF : 32'hFFFFFFFF);
            rd(12'h030 + 12'(k * 4), d);
            rd(12'h033 + 12'(k * 4), d);
        end
        wr(12'h040, 32'hFFFFFFFF);
        rd(12'h040, 32'h0);
        rd(12'h000, 32'h0);
        $display("test register access done");
        run(17'h0006F, 32'h0, 32'h0, 17'h10000, 100);
        $display("test memory-wide pass done");
        for (int f = 0; f < 8; f++) begin
            run({3'(f), 7'($random(seed)), 7'($random(seed))}, $random(seed),
                $random(seed), 17'($random(seed)), 60);
        end
        $display("test random filtering done");
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(12'h03C, 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule : data_trace_view_filter_regs_tb
